// ===== rtl/sem_host_pkg.sv
// Package: semaphore host constants, commands and timing counts
package sem_host_pkg;
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 16;
    localparam int          FLAG_CNT       = 8;
    localparam int          IDX_W          = 3;
    localparam int          FLAG_DATA_BIT  = 0;
    localparam int          CLK_PERIOD_NS  = 10;
    // Least strobe width per phase on the pins, rounded up to whole cycles
    localparam int          STROBE_NS      = 20;
    localparam int          STROBE_CYC_I   = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  STROBE_CYC     = 4'(STROBE_CYC_I);
    localparam logic [3:0]  CNT_ZERO       = 4'h0;
    localparam logic [3:0]  CNT_ONE        = 4'h1;
    localparam logic [2:0]  IDX_LAST       = 3'h7;
    localparam logic [1:0]  CMD_CLAIM      = 2'h0;
    localparam logic [1:0]  CMD_RELEASE    = 2'h1;
    localparam logic [1:0]  CMD_POLL       = 2'h2;
    localparam logic [1:0]  CMD_INIT       = 2'h3;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
endpackage

// ===== rtl/sem_phase_timer.sv
// Phase timer: counts strobe cycles and pulses when a phase has lasted long enough
`timescale 1ns/1ps
module sem_phase_timer
    import sem_host_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    output logic            done
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic       done_next;

    assign cnt_next  = start ? STROBE_CYC : (cnt_reg != CNT_ZERO ? cnt_reg - CNT_ONE : CNT_ZERO);
    assign done_next = (cnt_reg == CNT_ONE);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg <= CNT_ZERO;
            done    <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            done    <= done_next & ~start;
        end
    end
endmodule // sem_phase_timer

// ===== rtl/sem_host.sv
// Host-side controller driving one port of a two-port semaphore flag block
`timescale 1ns/1ps
// What this block does
// - Zero written claims, one releases
// - Select low plus address and read/write
// - Drop select between repeated reads
// - Write zero first, then read back
// - After failure reread or withdraw with one
// - Init writes one to every flag
// - Memory chip enable held high always
module sem_host
    import sem_host_pkg::*;
(
    input  wire logic              CLK_SYS,
    input  wire logic              SYS_RST,
    input  wire logic              CMD_VALID,
    input  wire logic [1:0]        CMD_OP,
    input  wire logic [IDX_W-1:0]  CMD_INDEX,
    output logic                   CMD_READY,
    output logic                   DONE,
    output logic                   GRANTED,
    output logic                   FLAG_SELECT_N,
    output logic                   CHIP_EN_N,
    output logic                   RW_N,
    output logic                   OUT_EN_N,
    output logic [ADDR_W-1:0]      ADDR,
    output logic [DATA_W-1:0]      DATA_OUT,
    output logic                   DATA_OE,
    input  wire logic [DATA_W-1:0] DATA_IN
);
    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WR    = 3'b001,
        ST_GAP   = 3'b010,
        ST_RD    = 3'b011,
        ST_CHECK = 3'b100
    } state_t;

    state_t            state_reg;
    state_t            state_next;
    logic [1:0]        op_reg;
    logic [IDX_W-1:0]  idx_reg;
    logic [DATA_W-1:0] din_s1_reg;
    logic [DATA_W-1:0] din_s2_reg;
    logic              timer_start;
    logic              phase_done;
    logic              read_is_zero;
    logic              do_read;
    logic              last_init;

    // Pin data is asynchronous to CLK_SYS: two flops before use
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            din_s1_reg <= DATA_RST;
            din_s2_reg <= DATA_RST;
        end
        else
        begin
            din_s1_reg <= DATA_IN;
            din_s2_reg <= din_s1_reg;
        end
    end

    sem_phase_timer u_timer (
        .clk   (CLK_SYS),
        .rst   (SYS_RST),
        .start (timer_start),
        .done  (phase_done)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Flag reads spread over all bits; bit zero is enough to judge ownership
    assign read_is_zero = ~din_s2_reg[FLAG_DATA_BIT];
    assign do_read      = (op_reg == CMD_CLAIM) || (op_reg == CMD_POLL);
    assign last_init    = (op_reg == CMD_INIT) && (idx_reg == IDX_LAST);
    assign timer_start  = (state_reg != state_next) && (state_next != ST_IDLE)
                          && (state_next != ST_CHECK);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (CMD_VALID && CMD_READY)
                    state_next = (CMD_OP == CMD_POLL) ? ST_RD : ST_WR;
            end
            ST_WR:
            begin
                if (phase_done)
                    state_next = ST_GAP;
            end
            ST_GAP:
            begin
                // Select goes high between phases so the read latch re-captures
                if (phase_done)
                begin
                    if (do_read)
                        state_next = ST_RD;
                    else if (op_reg == CMD_INIT && !last_init)
                        state_next = ST_WR;
                    else
                        state_next = ST_IDLE;
                end
            end
            ST_RD:
            begin
                if (phase_done)
                    state_next = ST_CHECK;
            end
            ST_CHECK:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Control registers and pins
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state_reg     <= ST_IDLE;
            op_reg        <= CMD_CLAIM;
            idx_reg       <= '0;
            CMD_READY     <= 1'b0;
            DONE          <= 1'b0;
            GRANTED       <= 1'b0;
            FLAG_SELECT_N <= 1'b1;
            CHIP_EN_N     <= 1'b1;
            RW_N          <= 1'b1;
            OUT_EN_N      <= 1'b1;
            ADDR          <= '0;
            DATA_OUT      <= DATA_RST;
            DATA_OE       <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            CHIP_EN_N     <= 1'b1;
            CMD_READY     <= (state_next == ST_IDLE);
            DONE          <= (state_reg != ST_IDLE) && (state_next == ST_IDLE);
            FLAG_SELECT_N <= !(state_next == ST_WR || state_next == ST_RD);
            RW_N          <= (state_next != ST_WR);
            OUT_EN_N      <= (state_next != ST_RD);
            DATA_OE       <= (state_next == ST_WR);
            ADDR          <= {{(ADDR_W-IDX_W){1'b0}}, idx_reg};
            if (state_reg == ST_IDLE && CMD_VALID && CMD_READY)
            begin
                op_reg   <= CMD_OP;
                idx_reg  <= (CMD_OP == CMD_INIT) ? '0 : CMD_INDEX;
                ADDR     <= {{(ADDR_W-IDX_W){1'b0}},
                             (CMD_OP == CMD_INIT) ? 3'h0 : CMD_INDEX};
                // Claim writes zero, release and init write one
                DATA_OUT <= (CMD_OP == CMD_CLAIM) ? DATA_RST : ~DATA_RST;
                GRANTED  <= 1'b0;
            end
            if (state_reg == ST_GAP && phase_done && op_reg == CMD_INIT && !last_init)
            begin
                // Address moves with the index on the same clock edge that select falls again
                idx_reg <= idx_reg + 3'h1;
                ADDR    <= {{(ADDR_W-IDX_W){1'b0}}, idx_reg + 3'h1};
            end
            if (state_reg == ST_CHECK)
                GRANTED <= read_is_zero;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_chip_en_high;
        @(posedge CLK_SYS) disable iff (SYS_RST) !FLAG_SELECT_N |-> CHIP_EN_N;
    endproperty
    a_chip_en_high: assert property (p_chip_en_high) else $error("chip enable low");

    property p_write_then_read;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (state_reg == ST_WR && op_reg == CMD_CLAIM) |-> ##[1:20] (!OUT_EN_N && RW_N);
    endproperty
    a_write_then_read: assert property (p_write_then_read) else $error("no readback");

    property p_gap_before_read;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        $fell(OUT_EN_N) |-> $past(FLAG_SELECT_N);
    endproperty
    a_gap_before_read: assert property (p_gap_before_read) else $error("no select gap");

    property p_claim_data;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (!RW_N && op_reg == CMD_CLAIM) |-> (DATA_OE && !DATA_OUT[FLAG_DATA_BIT]);
    endproperty
    a_claim_data: assert property (p_claim_data) else $error("claim not zero");

    property p_release_data;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (!RW_N && op_reg != CMD_CLAIM) |-> DATA_OUT[FLAG_DATA_BIT];
    endproperty
    a_release_data: assert property (p_release_data) else $error("release not one");

    property p_addr_low;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !FLAG_SELECT_N |-> (ADDR[ADDR_W-1:IDX_W] == '0);
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("high address set");

    sequence s_write_phase;
        !FLAG_SELECT_N && !RW_N;
    endsequence
    property p_write_width;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        $rose(DATA_OE) |-> s_write_phase [*2];
    endproperty
    a_write_width: assert property (p_write_width) else $error("short write");

    property p_grant_readback;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        (state_reg == ST_CHECK) |=> (GRANTED == !$past(din_s2_reg[FLAG_DATA_BIT]));
    endproperty
    a_grant_readback: assert property (p_grant_readback) else $error("grant wrong");
endmodule // sem_host

// ===== tb/sem_flag_model.sv
// Behavioural two-port semaphore flag device: port A on pins, port B by task
`timescale 1ns/1ps
module sem_flag_model
    import sem_host_pkg::*;
(
    input  wire logic              a_sel_n,
    input  wire logic              a_ce_n,
    input  wire logic              a_rw_n,
    input  wire logic              a_oe_n,
    input  wire logic              a_data_oe,
    input  wire logic [ADDR_W-1:0] a_addr,
    input  wire logic [DATA_W-1:0] a_wdata,
    output logic      [DATA_W-1:0] a_rdata
);
    logic [1:0]        own [FLAG_CNT];   // 0 free, 1 port A, 2 port B
    logic              req_a [FLAG_CNT]; // Left unknown until written
    logic              req_b [FLAG_CNT];
    logic [DATA_W-1:0] q_a;
    wire               rd_a = !a_sel_n && !a_oe_n && a_ce_n;

    task automatic wr(input bit sb, input logic [IDX_W-1:0] i, input logic d);
        logic [1:0] me;
        logic [1:0] other;
        me = sb ? 2'h2 : 2'h1;
        other = sb ? 2'h1 : 2'h2;
        if (sb) req_b[i] = d; else req_a[i] = d; // Non-owner zero stays pending
        // First zero to reach a free flag wins; calls never overlap here
        if (!d && own[i] !== 2'h1 && own[i] !== 2'h2)
            own[i] = me;
        // Only the owner's one frees; pending zero takes over at once
        if (d && own[i] !== other)
            own[i] = ((sb ? req_a[i] : req_b[i]) === 1'b0) ? other : 2'h0;
    endtask

    task automatic b_wr(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] d);
        wr(1'b1, i, d[FLAG_DATA_BIT]);
    endtask

    function automatic logic b_rd(input logic [IDX_W-1:0] i);
        return own[i] !== 2'h2;
    endfunction

    // Strobes come from one clock edge, so look once they have settled
    always @(negedge a_sel_n)
    begin
        #1;
        if (!a_rw_n && a_ce_n && a_data_oe === 1'b1)
            wr(1'b0, a_addr[2:0], a_wdata[FLAG_DATA_BIT]);
    end

    always @(posedge rd_a)
        q_a <= {DATA_W{own[a_addr[2:0]] !== 2'h1}};

    // A released bus shows the inverse so a stale value never passes
    assign a_rdata = rd_a ? q_a : ~q_a;
endmodule // sem_flag_model

// ===== tb/sem_host_tb_top.sv
// Testbench for the semaphore host controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin n_mismatch++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module sem_host_tb_top;
    import sem_host_pkg::*;
    logic              clk_sys, sys_rst, cmd_valid, cmd_ready, done, granted;
    logic              sel_n, ce_n, rw_n, oe_n, data_oe;
    logic [1:0]        cmd_op;
    logic [IDX_W-1:0]  cmd_index;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    int                n_mismatch, cmp_count, seed;
    int                own_e [FLAG_CNT];
    bit                pa [FLAG_CNT];
    bit                pb [FLAG_CNT];

    sem_host dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CMD_VALID(cmd_valid),
        .CMD_OP(cmd_op), .CMD_INDEX(cmd_index), .CMD_READY(cmd_ready), .DONE(done),
        .GRANTED(granted), .FLAG_SELECT_N(sel_n), .CHIP_EN_N(ce_n), .RW_N(rw_n),
        .OUT_EN_N(oe_n), .ADDR(addr), .DATA_OUT(wdata), .DATA_OE(data_oe), .DATA_IN(rdata));
    sem_flag_model m (.a_sel_n(sel_n), .a_ce_n(ce_n), .a_rw_n(rw_n), .a_oe_n(oe_n),
        .a_data_oe(data_oe),
        .a_addr(addr), .a_wdata(wdata), .a_rdata(rdata));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Expected ownership: 0 free, 1 this port, 2 far port
    task automatic ref_wr(input bit sb, input int i, input bit d);
        if (sb) pb[i] = d; else pa[i] = d;
        if (!d && own_e[i] == 0) own_e[i] = sb ? 2 : 1;
        if (d && own_e[i] == (sb ? 2 : 1)) own_e[i] = ((sb ? pa[i] : pb[i]) == 0) ? (sb ? 1 : 2) : 0;
    endtask

    task automatic bw(input int i, input logic [DATA_W-1:0] d);
        m.b_wr(i[2:0], d);
        ref_wr(1'b1, i, d[0]);
        `CHK("far_flag", own_e[i] != 2, m.b_rd(i[2:0]))
    endtask

    task automatic cmd(input logic [1:0] op, input int i);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100) begin @(negedge clk_sys); n++; end
        `CHK("ready", 1'b1, cmd_ready)
        cmd_op = op;
        cmd_index = i[2:0];
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 1000) begin @(negedge clk_sys); n++; end
        `CHK("done", 1'b1, done)
        if (op == CMD_INIT) for (int k = 0; k < FLAG_CNT; k++) ref_wr(1'b0, k, 1'b1);
        else if (op != CMD_POLL) ref_wr(1'b0, i, op == CMD_RELEASE);
        @(negedge clk_sys);
        if (op == CMD_CLAIM || op == CMD_POLL) `CHK("granted", own_e[i] == 1, granted)
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        // About seventy commands, all but the init under twenty cycles each, with ample margin
        #100000;
        n_mismatch++;
        $display("ERROR watchdog expected 1 seen 0");
        end_sim();
    end

    initial
    begin
        seed = 32'hd6fef552;
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = CMD_INIT;
        cmd_index = 3'h0;
        for (int k = 0; k < FLAG_CNT; k++) own_e[k] = 0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys) sys_rst = 1'b0;
        // Both sides write ones so every flag starts free
        for (int k = 0; k < FLAG_CNT; k++) bw(k, 16'hfffe ^ 16'h0001);
        cmd(CMD_INIT, 0);
        for (int k = 0; k < FLAG_CNT; k++) cmd(CMD_CLAIM, k);
        $display("test init_claim_all done");
        bw(5, 16'hfffe);
        cmd(CMD_RELEASE, 5);
        cmd(CMD_POLL, 5);
        cmd(CMD_CLAIM, 5);
        bw(5, 16'h0001);
        cmd(CMD_POLL, 5);
        $display("test handover done");
        for (int t = 0; t < 60; t++)
        begin
            if ($random(seed) & 1) bw($random(seed) & 7, $random(seed));
            cmd(2'(($random(seed) & 32'h7fffffff) % 3), $random(seed) & 7);
        end
        $display("test random_mix done");
        end_sim();
    end
endmodule // sem_host_tb_top
